// *** design/crcu_top.sv ***
// bus-attached crc16/crc32 checksum calculator with apb register access
// How it works
// - the standard 16-bit code folds data with generator 0x8005.
// - the telecom 16-bit code folds data with generator 0x1021.
// - the 32-bit code folds data with the ethernet generator 0x04c11db7.
// - complement, byte reversal and bit reversal are each selectable on data and on checksum.
// - data writes of one, two or four bytes are folded according to the chosen size.
// - a seed write loads the accumulator, and folding starts from that value.
// - a byte write is absorbed in one clock and a word write in four clocks.
// - the checksum reads back 16 bits wide in 16-bit modes and 32 bits in 32-bit mode.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module crcu_top
    import crcu_pkg::*;
(
    input wire logic pclk,           // 125 MHz bus clock
    input wire logic presetn,        // async reset, active low
    input wire logic psel,           // apb select
    input wire logic penable,        // apb access phase
    input wire logic pwrite,         // apb direction
    input wire logic [11:0] paddr,   // apb byte address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [3:0] pstrb,    // apb byte strobes
    output logic pready,             // apb ready
    output logic [31:0] prdata,      // apb read data
    output logic pslverr             // apb error
);
    import crcu_pkg::*;

    typedef enum logic {CRCU_IDLE, CRCU_BUSY} crcu_state_t;

    logic [31:0] ctrl;
    logic [31:0] crc;
    logic [31:0] shreg;
    logic [2:0] left;
    crcu_state_t state;
    logic [31:0] poly;
    logic wide;
    logic [31:0] dsh;
    logic [2:0] nbytes;
    logic [31:0] step_out;
    logic [31:0] csum;
    logic setup;
    logic access;
    logic hit;
    logic [31:0] bmask;
    crcu_size_t size;

    // byte lanes written under the strobes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    assign size = crcu_size_t'(ctrl[CRCU_SIZE_LSB +: 2]);
    assign wide = (ctrl[CRCU_POLY_LSB +: 2] == CRCU_POLY_ETH32);

    // generator select
    always_comb begin
        unique case (ctrl[CRCU_POLY_LSB +: 2])
            CRCU_POLY_STD16: poly = CRCU_POLY16_STD;
            CRCU_POLY_TEL16: poly = CRCU_POLY16_TEL;
            CRCU_POLY_ETH32: poly = CRCU_POLY32_ETH;
            default: poly = CRCU_POLY16_STD;
        endcase
    end

    // size of the written unit
    always_comb begin
        unique case (size)
            CRCU_SIZE_BYTE: nbytes = CRCU_BYTES_BYTE;
            CRCU_SIZE_HALF: nbytes = CRCU_BYTES_HALF;
            default: nbytes = CRCU_BYTES_WORD;
        endcase
    end

    // data pre-processing: complement, then byte order, then bit order per byte;
    // the unit sits in the low bits and is left-aligned so bytes go out msb first
    always_comb begin
        logic [31:0] d;
        d = pwdata;
        if (ctrl[CRCU_DCMP_BIT]) begin
            d = ~d;
        end
        if (ctrl[CRCU_DBYT_BIT]) begin
            unique case (size)
                CRCU_SIZE_BYTE: d = d;
                CRCU_SIZE_HALF: d = {16'h0000, d[7:0], d[15:8]};
                default: d = {d[7:0], d[15:8], d[23:16], d[31:24]};
            endcase
        end
        if (ctrl[CRCU_DBIT_BIT]) begin
            for (int b = 0; b < 4; b++) begin
                d[b*8 +: 8] = {<<{d[b*8 +: 8]}};
            end
        end
        unique case (size)
            CRCU_SIZE_BYTE: dsh = {d[7:0], 24'h000000};
            CRCU_SIZE_HALF: dsh = {d[15:0], 16'h0000};
            default: dsh = d;
        endcase
    end

    crcu_byte_step u_step (
        .crc_in(crc),
        .data(shreg[31:24]),
        .poly(poly),
        .wide(wide),
        .crc_out(step_out)
    );

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit = (paddr == CRCU_CTRL_OFS) || (paddr == CRCU_SEED_OFS)
        || (paddr == CRCU_CSUM_OFS) || (paddr == CRCU_DATA_OFS)
        || (paddr == CRCU_STAT_OFS);

    // a data write while busy waits, so back-to-back word writes land five clocks apart
    assign pready = !(state == CRCU_BUSY && pwrite && paddr == CRCU_DATA_OFS);
    assign pslverr = access && !hit;

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CRCU_CTRL_RST;
        end else if (access && pready && pwrite && paddr == CRCU_CTRL_OFS) begin
            ctrl <= ((ctrl & ~bmask) | (pwdata & bmask)) & CRCU_CTRL_MASK;
        end
    end

    // accumulator: seed load, or one byte folded per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= CRCU_SEED_RST;
        end else if (access && pwrite && paddr == CRCU_SEED_OFS) begin
            crc <= wide ? pwdata : (pwdata & CRCU_MASK16);
        end else if (state == CRCU_BUSY) begin
            crc <= step_out;
        end
    end

    // byte sequencer for the unit in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CRCU_IDLE;
            shreg <= 32'h0000_0000;
            left <= 3'h0;
        end else begin
            unique case (state)
                CRCU_IDLE: begin
                    if (access && pwrite && paddr == CRCU_DATA_OFS) begin
                        shreg <= dsh;
                        left <= nbytes;
                        state <= CRCU_BUSY;
                    end
                end
                CRCU_BUSY: begin
                    shreg <= {shreg[23:0], 8'h00};
                    left <= left - 3'h1;
                    if (left == 3'h1) begin
                        state <= CRCU_IDLE;
                    end
                end
            endcase
        end
    end

    // checksum post-processing on the read path
    always_comb begin
        logic [31:0] c;
        c = crc;
        if (ctrl[CRCU_SBIT_BIT]) begin
            // streaming kept as a plain assignment source; a select on it is not portable
            if (wide) begin
                c = {<<{crc}};
            end else begin
                c[15:0] = {<<{crc[15:0]}};
                c[31:16] = 16'h0000;
            end
        end
        if (ctrl[CRCU_SBYT_BIT]) begin
            c = wide ? {c[7:0], c[15:8], c[23:16], c[31:24]}
                : {16'h0000, c[7:0], c[15:8]};
        end
        if (ctrl[CRCU_SCMP_BIT]) begin
            c = ~c;
        end
        csum = wide ? c : (c & CRCU_MASK16);
    end

    // read data is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                CRCU_CTRL_OFS: prdata <= ctrl;
                CRCU_SEED_OFS: prdata <= crc;
                CRCU_CSUM_OFS: prdata <= csum;
                CRCU_STAT_OFS: prdata <= {31'h0, state == CRCU_BUSY};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // byte write absorbed in exactly one busy clock
    sequence start_byte_s;
        state == CRCU_IDLE && access && pwrite && paddr == CRCU_DATA_OFS
            && size == CRCU_SIZE_BYTE;
    endsequence
    byte_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_byte_s |=> state == CRCU_BUSY ##1 state == CRCU_IDLE)
        else $error("byte write not absorbed in one clock");
    sequence start_word_s;
        state == CRCU_IDLE && access && pwrite && paddr == CRCU_DATA_OFS
            && size == CRCU_SIZE_WORD;
    endsequence
    word_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_word_s |=> (state == CRCU_BUSY) [*4] ##1 state == CRCU_IDLE)
        else $error("word write not absorbed in four clocks");
    seed_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == CRCU_SEED_OFS && state == CRCU_IDLE
            |=> crc == ($past(wide) ? $past(pwdata) : ($past(pwdata) & CRCU_MASK16)))
        else $error("seed not loaded");
    narrow_csum_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wide |-> csum[31:16] == 16'h0000)
        else $error("16-bit checksum has high bits");
    narrow_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wide && $past(state) == CRCU_BUSY |-> crc[31:16] == 16'h0000)
        else $error("16-bit remainder overflow");
    poly_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[CRCU_POLY_LSB +: 2] == CRCU_POLY_TEL16 |-> poly == CRCU_POLY16_TEL)
        else $error("wrong telecom generator");
    eth_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[CRCU_POLY_LSB +: 2] == CRCU_POLY_ETH32 |-> poly == CRCU_POLY32_ETH && wide)
        else $error("wrong 32-bit generator");
    csum_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
        wide && ctrl[CRCU_SCMP_BIT] && !ctrl[CRCU_SBYT_BIT] && !ctrl[CRCU_SBIT_BIT]
            |-> csum == ~crc)
        else $error("checksum complement wrong");
    acc_update_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == CRCU_BUSY |=> crc == $past(step_out))
        else $error("accumulator not updated");
    half_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == CRCU_IDLE && access && pwrite && paddr == CRCU_DATA_OFS
            && size == CRCU_SIZE_HALF |=> left == CRCU_BYTES_HALF)
        else $error("half-word length wrong");
endmodule // crcu_top
`default_nettype wire

// *** design/crcu_pkg.sv ***
// package for the checksum calculator: register map, fields, polynomials, timing
package crcu_pkg;
    // register byte offsets
    localparam logic [11:0] CRCU_CTRL_OFS = 12'h000;
    localparam logic [11:0] CRCU_SEED_OFS = 12'h004;
    localparam logic [11:0] CRCU_CSUM_OFS = 12'h008;
    localparam logic [11:0] CRCU_DATA_OFS = 12'h00c;
    localparam logic [11:0] CRCU_STAT_OFS = 12'h010;
    // control fields
    localparam int CRCU_POLY_LSB = 0;
    localparam int CRCU_DCMP_BIT = 2;
    localparam int CRCU_DBYT_BIT = 3;
    localparam int CRCU_DBIT_BIT = 4;
    localparam int CRCU_SCMP_BIT = 5;
    localparam int CRCU_SBYT_BIT = 6;
    localparam int CRCU_SBIT_BIT = 7;
    localparam int CRCU_SIZE_LSB = 8;
    localparam logic [31:0] CRCU_CTRL_MASK = 32'h0000_03ff;
    localparam logic [31:0] CRCU_CTRL_RST = 32'h0000_0200;
    localparam logic [31:0] CRCU_SEED_RST = 32'h0000_0000;
    // polynomial selection codes
    typedef enum logic [1:0] {
        CRCU_POLY_STD16 = 2'h0,
        CRCU_POLY_TEL16 = 2'h1,
        CRCU_POLY_ETH32 = 2'h2
    } crcu_poly_t;
    // input unit size codes
    typedef enum logic [1:0] {
        CRCU_SIZE_BYTE = 2'h0,
        CRCU_SIZE_HALF = 2'h1,
        CRCU_SIZE_WORD = 2'h2
    } crcu_size_t;
    localparam logic [31:0] CRCU_POLY16_STD = 32'h0000_8005;
    localparam logic [31:0] CRCU_POLY16_TEL = 32'h0000_1021;
    localparam logic [31:0] CRCU_POLY32_ETH = 32'h04c1_1db7;
    localparam logic [31:0] CRCU_MASK16 = 32'h0000_ffff;
    // one byte is absorbed per clock
    localparam int CRCU_BYTE_BITS = 8;
    localparam logic [2:0] CRCU_BYTES_BYTE = 3'h1;
    localparam logic [2:0] CRCU_BYTES_HALF = 3'h2;
    localparam logic [2:0] CRCU_BYTES_WORD = 3'h4;
endpackage

// *** design/crcu_byte_step.sv ***
// combinational fold of one byte into the running remainder
`timescale 1ns/1ps
`default_nettype none
module crcu_byte_step (
    input wire logic [31:0] crc_in,  // running remainder
    input wire logic [7:0] data,     // byte, msb first
    input wire logic [31:0] poly,    // generator without top bit
    input wire logic wide,           // 1 = 32-bit remainder
    output logic [31:0] crc_out      // updated remainder
);
    // bit-serial unroll; the top bit position moves with the width
    always_comb begin
        logic [31:0] c;
        logic top;
        c = crc_in;
        top = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            top = (wide ? c[31] : c[15]) ^ data[i];
            c = {c[30:0], 1'b0};
            if (top) begin
                c = c ^ poly;
            end
            if (!wide) begin
                c[31:16] = 16'h0000;
            end
        end
        crc_out = c;
    end
endmodule // crcu_byte_step
`default_nettype wire

// *** test/crcu_apb_master.sv ***
// apb master model standing in for the processor or dma side
`timescale 1ns/1ps
`default_nettype none
module crcu_apb_master (
    input wire logic pclk,          // bus clock
    output logic psel,              // select
    output logic penable,           // access phase
    output logic pwrite,            // direction
    output logic [11:0] paddr,      // byte address
    output logic [31:0] pwdata,     // write data
    output logic [3:0] pstrb,       // byte strobes
    input wire logic pready,        // slave ready
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr        // slave error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // one transfer, entered just after a rising edge; select stays up so the
    // next setup can follow at once without assigning anything twice
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        // ready, read data and error are all taken at the one rising edge that ends
        // the access; a stalled slave is left to the bench watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
    endtask
    // drop select; write data is scrambled so nothing stale looks valid
    task automatic idle();
        psel <= 1'b0;
        pwdata <= ~pwdata;
        @(posedge pclk);
    endtask
endmodule // crcu_apb_master
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the checksum calculator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crcu_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb;
    int bad_count = 0;
    int checks_done = 0;

    always #4 pclk = ~pclk;

    crcu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    crcu_apb_master i_master (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] rbits(logic [31:0] v, int w);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < w; i++) r[i] = v[w-1-i];
        return r;
    endfunction

    function automatic logic [31:0] rbytes(logic [31:0] v, int nb);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < nb; i++) r[8*i+:8] = v[8*(nb-1-i)+:8];
        return r;
    endfunction

    // reference fold: unit prepared, then msb byte first, bit 7 first
    function automatic logic [31:0] fold(logic [31:0] crc, logic [31:0] u, int nb,
                                         logic [9:0] c);
        logic [31:0] p;
        int w;
        logic t;
        w = (c[1:0] == 2'h2) ? 32 : 16;
        p = (c[1:0] == 2'h1) ? CRCU_POLY16_TEL : (w == 32) ? CRCU_POLY32_ETH : CRCU_POLY16_STD;
        if (c[CRCU_DCMP_BIT]) u = ~u;
        u = u & ((32'h1 << (8 * nb)) - 32'h1);
        if (c[CRCU_DBYT_BIT]) u = rbytes(u, nb);
        for (int b = nb - 1; b >= 0; b--) begin
            for (int i = 7; i >= 0; i--) begin
                t = crc[w-1] ^ (c[CRCU_DBIT_BIT] ? u[8*b+7-i] : u[8*b+i]);
                crc = (crc << 1) ^ (t ? p : 32'h0);
            end
        end
        return (w == 32) ? crc : crc & CRCU_MASK16;
    endfunction

    function automatic logic [31:0] post(logic [31:0] v, logic [9:0] c);
        int w;
        w = (c[1:0] == 2'h2) ? 32 : 16;
        if (c[CRCU_SBIT_BIT]) v = rbits(v, w);
        if (c[CRCU_SBYT_BIT]) v = rbytes(v, w / 8);
        if (c[CRCU_SCMP_BIT]) v = ~v;
        return (w == 32) ? v : v & CRCU_MASK16;
    endfunction

    // about 48 tests of some 20 cycles; generous margin before giving up
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end

    initial begin
        logic [9:0] c;
        logic [31:0] crc, s, u;
        int nb, n;
        longint t0;
        void'($urandom(78629));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset value, then an unmapped write must bounce and change nothing
        i_master.xfer(1'b0, CRCU_CTRL_OFS, 32'h0, rv, ev);
        check(rv, CRCU_CTRL_RST);
        i_master.xfer(1'b1, 12'h014, 32'h0000_0001, rv, ev);
        check({31'h0, ev}, 32'h1);
        i_master.xfer(1'b0, 12'h014, 32'h0, rv, ev);
        check(rv, 32'h0);
        check({31'h0, ev}, 32'h1);
        i_master.xfer(1'b0, CRCU_CTRL_OFS, 32'h0, rv, ev);
        check(rv, CRCU_CTRL_RST);
        $display("test reset and unmapped done");
        // every polynomial and size code, seed zero, all ones and random
        for (int k = 0; k < 48; k++) begin
            c = {k[3:2], 6'($urandom), k[1:0]};
            s = (k[5:4] == 2'h0) ? 32'h0 : (k[5:4] == 2'h1) ? 32'hffff_ffff : $urandom;
            if (k[1:0] != 2'h2) s = s & CRCU_MASK16;
            nb = (k[3:2] == 2'h0) ? 1 : (k[3:2] == 2'h1) ? 2 : 4;
            i_master.xfer(1'b1, CRCU_CTRL_OFS, {22'h0, c}, rv, ev);
            i_master.xfer(1'b1, CRCU_SEED_OFS, s, rv, ev);
            i_master.xfer(1'b0, CRCU_SEED_OFS, 32'h0, rv, ev);
            check(rv, s);
            check({31'h0, ev}, 32'h0);
            crc = s;
            t0 = 0;
            // back-to-back data writes; spacing shows the absorb time
            repeat (1 + $urandom % 4) begin
                u = $urandom;
                i_master.xfer(1'b1, CRCU_DATA_OFS, u, rv, ev);
                if (t0 != 0) check(32'($time - t0), 32'((nb + 1) * 8));
                t0 = $time;
                crc = fold(crc, u, nb, c);
            end
            n = 0;
            do begin
                i_master.xfer(1'b0, CRCU_STAT_OFS, 32'h0, rv, ev);
                n++;
            end while (rv[0] !== 1'b0 && n < 50);
            check({31'h0, rv[0]}, 32'h0);
            i_master.xfer(1'b0, CRCU_CSUM_OFS, 32'h0, rv, ev);
            check(rv, post(crc, c));
            $display("test %0d poly %0d size %0d done", k, c[1:0], c[9:8]);
        end
        // second reset while a word is still being folded restores the defaults
        i_master.xfer(1'b1, CRCU_CTRL_OFS, 32'h0000_02e2, rv, ev);
        i_master.xfer(1'b1, CRCU_DATA_OFS, $urandom, rv, ev);
        i_master.idle();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        i_master.xfer(1'b0, CRCU_STAT_OFS, 32'h0, rv, ev);
        check(rv, 32'h0);
        i_master.xfer(1'b0, CRCU_CTRL_OFS, 32'h0, rv, ev);
        check(rv, CRCU_CTRL_RST);
        i_master.xfer(1'b0, CRCU_SEED_OFS, 32'h0, rv, ev);
        check(rv, CRCU_SEED_RST);
        i_master.idle();
        $display("test second reset done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
